// ===== logic/dst_pkg.sv
/*
  Constants for the dual 8-bit split timer: register offsets, field positions,
  reset values, command encodings and the prescaler width.
  Assumes byte-wide registers reached over a plain strobe port.
*/
package dst_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] prescale_and_enable_addr    = 6'h00;
  localparam logic [5:0] compare_output_enables_addr = 6'h01;
  localparam logic [5:0] forced_output_values_addr   = 6'h02;
  localparam logic [5:0] split_select_addr           = 6'h03;
  localparam logic [5:0] command_clear_addr          = 6'h04;
  localparam logic [5:0] command_set_addr            = 6'h05;
  localparam logic [5:0] interrupt_enables_addr      = 6'h0A;
  localparam logic [5:0] interrupt_flags_addr        = 6'h0B;
  localparam logic [5:0] low_counter_value_addr      = 6'h20;
  localparam logic [5:0] high_counter_value_addr     = 6'h21;
  localparam logic [5:0] low_period_addr             = 6'h26;
  localparam logic [5:0] high_period_addr            = 6'h27;
  localparam logic [5:0] compare_base_addr           = 6'h28;
  localparam logic [5:0] compare_last_addr           = 6'h2D;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int enable_bit           = 0;
  localparam int divider_lsb          = 1;
  localparam int split_bit            = 0;
  localparam int command_lsb          = 2;
  localparam int target_lsb           = 0;
  localparam int high_field_lsb       = 4;
  localparam int flag_low_underflow   = 0;
  localparam int flag_high_underflow  = 1;
  localparam int flag_compare_lsb     = 4;
  localparam logic [7:0] reg_reset    = 8'h00;
  localparam logic [7:0] period_reset = 8'hFF;
  localparam logic [7:0] prescale_and_enable_mask   = 8'h0F;
  localparam logic [7:0] channel_mask = 8'h77;
  localparam logic [7:0] target_mask  = 8'h03;
  localparam logic [7:0] flag_mask    = 8'h73;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] cmd_none    = 2'h0;
  localparam logic [1:0] cmd_restart = 2'h2;
  localparam logic [1:0] cmd_reset   = 2'h3;

  // Prescaler counter width; the timer picks a tap for each divider code, and code 0 counts every cycle.
  localparam int prescale_width = 10;

endpackage

// ===== logic/dst_byte_counter.sv
/*
  One 8-bit down-counter of the split timer with three compare channels.
  Assumes a one-cycle count enable from the shared prescaler.
*/
`timescale 1ns/1ps
module dst_byte_counter
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       count_tick,
  input  wire logic       restart,
  input  wire logic       hard_reset,
  input  wire logic       write_count,
  input  wire logic [7:0] write_data,
  input  wire logic [7:0] period,
  input  wire logic [7:0] compare0,
  input  wire logic [7:0] compare1,
  input  wire logic [7:0] compare2,
  output logic      [7:0] count,
  output logic            underflow,
  output logic      [2:0] match
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A bus write wins over count, restart and hard reset in the same cycle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      count <= dst_pkg::reg_reset;
    else if (write_count)
      count <= write_data;
    else if (hard_reset)
      count <= dst_pkg::reg_reset;
    else if (restart)
      count <= period;
    else if (count_tick)
      count <= (count == 8'h00) ? period : count - 8'h01;
  end

  // Underflow is the tick that leaves BOTTOM.
  assign underflow = count_tick && !write_count && !restart && !hard_reset && (count == 8'h00);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  assign match[0] = (count == compare0);
  assign match[1] = (count == compare1);
  assign match[2] = (count == compare2);

endmodule

// ===== logic/dst_split_timer.sv
/*
  Control, command and flag logic of a 16-bit timer in split mode, run as two
  8-bit down-counters, with waveform outputs and an interrupt request.
  Assumes software on a plain byte register port; read data one cycle later.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module dst_split_timer
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [5:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  input  wire logic [2:0] waveform_mode_active,
  output logic      [7:0] read_data,
  output logic      [5:0] waveform_pin_n,
  output logic      [5:0] waveform_pin_override,
  output logic            interrupt_request
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] prescale_and_enable;
  logic [7:0] compare_output_enables;
  logic [7:0] forced_output_values;
  logic [7:0] split_select;
  logic [1:0] command_target;
  logic [7:0] interrupt_enables;
  logic [7:0] interrupt_flags;
  logic [7:0] low_period;
  logic [7:0] high_period;
  logic [7:0] compare_value [0:5];
  logic [9:0] prescale_count;
  logic       count_tick;
  logic [7:0] low_counter_value;
  logic [7:0] high_counter_value;
  logic       low_underflow;
  logic       high_underflow;
  logic [2:0] low_compare_match;
  logic [5:0] waveform_level;
  logic [7:0] next_flags;
  logic [7:0] next_read;
  logic       wr_clear;
  logic       wr_set;
  logic [1:0] cmd_code;
  logic [1:0] cmd_sel;
  logic       enabled;
  logic       dual_byte_counter_select;
  logic [1:0] restart_sel;
  logic [1:0] hard_reset_sel;

  assign enabled                  = prescale_and_enable[dst_pkg::enable_bit];
  assign dual_byte_counter_select = split_select[dst_pkg::split_bit];
  // One decoder serves both command registers.
  assign wr_clear                 = write_strobe && (address == dst_pkg::command_clear_addr);
  assign wr_set                   = write_strobe && (address == dst_pkg::command_set_addr);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      prescale_and_enable    <= dst_pkg::reg_reset;
      compare_output_enables <= dst_pkg::reg_reset;
      forced_output_values   <= dst_pkg::reg_reset;
      split_select           <= dst_pkg::reg_reset;
      interrupt_enables      <= dst_pkg::reg_reset;
      low_period             <= dst_pkg::period_reset;
      high_period            <= dst_pkg::period_reset;
    end
    else if (write_strobe)
    begin
      case (address)
        dst_pkg::prescale_and_enable_addr:    prescale_and_enable    <= write_data & dst_pkg::prescale_and_enable_mask;
        dst_pkg::compare_output_enables_addr: compare_output_enables <= write_data & dst_pkg::channel_mask;
        dst_pkg::forced_output_values_addr:   forced_output_values   <= write_data & dst_pkg::channel_mask;
        dst_pkg::split_select_addr:           split_select           <= {7'h00, write_data[0]};
        dst_pkg::interrupt_enables_addr:      interrupt_enables      <= write_data & dst_pkg::flag_mask;
        dst_pkg::low_period_addr:             low_period             <= write_data;
        dst_pkg::high_period_addr:            high_period            <= write_data;
        default:                              ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 6; i++)
        compare_value[i] <= dst_pkg::reg_reset;
    end
    else if (write_strobe && address >= dst_pkg::compare_base_addr && address <= dst_pkg::compare_last_addr)
    begin
      // Even offsets are low channels, odd ones high.
      compare_value[3'(address - dst_pkg::compare_base_addr)] <= write_data;
    end
  end

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  // Only the target field is stored; the command field acts once and is gone.
  always_ff @(posedge clock or negedge nrst)
  begin
    // Set and clear never come together on the bus.
    if (!nrst)
    begin
      command_target <= 2'h0;
    end
    else if (wr_set)
    begin
      command_target <= command_target | write_data[1:0];
    end
    else if (wr_clear)
    begin
      command_target <= command_target & ~write_data[1:0];
    end
  end

  assign cmd_code = write_data[dst_pkg::command_lsb +: 2];
  // The command applies to the target as written in the same access.
  assign cmd_sel  = write_data[dst_pkg::target_lsb +: 2];

  // A clear write with a command acts the same as a set write with it.
  always_comb
  begin
    restart_sel    = 2'b00;
    hard_reset_sel = 2'b00;
    if ((wr_set || wr_clear) && dual_byte_counter_select)
    begin
      case (cmd_code)
        dst_pkg::cmd_restart: restart_sel = cmd_sel;
        // Hard reset of a running timer is refused.
        dst_pkg::cmd_reset:   hard_reset_sel = enabled ? 2'b00 : cmd_sel;
        default:              ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    // Restart zeroes the prescaler for a full first period.
    if (!nrst)
    begin
      prescale_count <= 10'h000;
    end
    else if (!enabled || restart_sel != 2'b00)
    begin
      prescale_count <= 10'h000;
    end
    else
    begin
      prescale_count <= prescale_count + 10'h001;
    end
  end

  // A tick fires when all bits below the selected tap are ones.
  always_comb
  begin
    case (prescale_and_enable[dst_pkg::divider_lsb +: 3])
      3'h0:    count_tick = 1'b1;
      3'h1:    count_tick = &prescale_count[0:0];
      3'h2:    count_tick = &prescale_count[1:0];
      3'h3:    count_tick = &prescale_count[2:0];
      3'h4:    count_tick = &prescale_count[3:0];
      3'h5:    count_tick = &prescale_count[5:0];
      3'h6:    count_tick = &prescale_count[7:0];
      3'h7:    count_tick = &prescale_count[9:0];
      default: count_tick = 1'b0;
    endcase
    // No counting outside split mode; 16-bit mode is absent.
    count_tick = count_tick && enabled && dual_byte_counter_select;
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  dst_byte_counter low_counter
  (
    .clock       (clock),
    .nrst        (nrst),
    .count_tick  (count_tick),
    .restart     (restart_sel[0]),
    .hard_reset  (hard_reset_sel[0]),
    .write_count (write_strobe && address == dst_pkg::low_counter_value_addr),
    .write_data  (write_data),
    .period      (low_period),
    .compare0    (compare_value[0]),
    .compare1    (compare_value[2]),
    .compare2    (compare_value[4]),
    .count       (low_counter_value),
    .underflow   (low_underflow),
    .match       (low_compare_match)
  );

  // High compares raise no flag here; match is left open.
  dst_byte_counter high_counter
  (
    .clock       (clock),
    .nrst        (nrst),
    .count_tick  (count_tick),
    .restart     (restart_sel[1]),
    .hard_reset  (hard_reset_sel[1]),
    .write_count (write_strobe && address == dst_pkg::high_counter_value_addr),
    .write_data  (write_data),
    .period      (high_period),
    .compare0    (compare_value[1]),
    .compare1    (compare_value[3]),
    .compare2    (compare_value[5]),
    .count       (high_counter_value),
    .underflow   (high_underflow),
    .match       ()
  );

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  // A standing match sets its flag again after a clear.
  // Set wins over a clear arriving in the same cycle, so no event is lost.
  always_comb
  begin
    next_flags = interrupt_flags;
    if (write_strobe && address == dst_pkg::interrupt_flags_addr)
      next_flags = next_flags & ~(write_data & dst_pkg::flag_mask);
    if (dual_byte_counter_select)
    begin
      next_flags[dst_pkg::flag_compare_lsb +: 3] =
        next_flags[dst_pkg::flag_compare_lsb +: 3] | low_compare_match;
      next_flags[dst_pkg::flag_high_underflow] =
        next_flags[dst_pkg::flag_high_underflow] | high_underflow;
      next_flags[dst_pkg::flag_low_underflow] =
        next_flags[dst_pkg::flag_low_underflow] | low_underflow;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      interrupt_flags <= dst_pkg::reg_reset;
    end
    else
    begin
      interrupt_flags <= next_flags;
    end
  end

  // Plain level request; no edge shaping here.
  assign interrupt_request = |(interrupt_flags & interrupt_enables);

  // ----------------------------------------------------------------
  // Waveform outputs
  // ----------------------------------------------------------------
  // Low channels sit at bits 2:0, high channels at bits 6:4 of the registers.
  // The generator here is a plain compare level; the pin mux lives outside.
  // Forced levels follow each disabled cycle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      waveform_level <= 6'h00;
    else if (!enabled)
      waveform_level <= {forced_output_values[6:4], forced_output_values[2:0]};
    else if (count_tick)
      waveform_level <= {high_counter_value > compare_value[5], high_counter_value > compare_value[3],
                         high_counter_value > compare_value[1], low_counter_value > compare_value[4],
                         low_counter_value > compare_value[2], low_counter_value > compare_value[0]};
  end

  assign waveform_pin_n = waveform_level;

  // Override needs both the enable bit and a waveform mode on that side.
  assign waveform_pin_override = {compare_output_enables[6:4] & {3{waveform_mode_active[1]}},
                                  compare_output_enables[2:0] & {3{waveform_mode_active[0]}}};

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    case (address)
      dst_pkg::prescale_and_enable_addr:    next_read = prescale_and_enable;
      dst_pkg::compare_output_enables_addr: next_read = compare_output_enables;
      dst_pkg::forced_output_values_addr:   next_read = forced_output_values;
      dst_pkg::split_select_addr:           next_read = split_select;
      dst_pkg::command_clear_addr,
      dst_pkg::command_set_addr:            next_read = {6'h00, command_target};
      dst_pkg::interrupt_enables_addr:      next_read = interrupt_enables;
      dst_pkg::interrupt_flags_addr:        next_read = interrupt_flags;
      dst_pkg::low_counter_value_addr:      next_read = low_counter_value;
      dst_pkg::high_counter_value_addr:     next_read = high_counter_value;
      dst_pkg::low_period_addr:             next_read = low_period;
      dst_pkg::high_period_addr:            next_read = high_period;
      default:
        if (address >= dst_pkg::compare_base_addr && address <= dst_pkg::compare_last_addr)
          next_read = compare_value[3'(address - dst_pkg::compare_base_addr)];
        else
          next_read = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    // Idle cycles read zero, so a stale byte is not retaken.
    if (!nrst)
    begin
      read_data <= 8'h00;
    end
    else if (read_strobe)
    begin
      read_data <= next_read;
    end
    else
    begin
      read_data <= 8'h00;
    end
  end

endmodule

// ===== verification/dst_split_timer_chk.sv
/*
  Port-level assertions for the split timer control block.
  Assumes the single clock and active-low asynchronous reset of the design top.
*/
`timescale 1ns/1ps
module dst_split_timer_chk
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [5:0] address,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire logic [2:0] waveform_mode_active,
  input wire logic [7:0] read_data,
  input wire logic [5:0] waveform_pin_n,
  input wire logic [5:0] waveform_pin_override,
  input wire logic       interrupt_request
);
  default clocking dst_cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  // Shadows are rebuilt from bus writes so that level checks need no internal probes.
  logic       sh_en;
  logic [7:0] sh_lvl;
  logic [7:0] sh_ie;
  logic [1:0] quiet;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_en  <= 1'b0;
      sh_lvl <= 8'h00;
      sh_ie  <= 8'h00;
    end
    else if (write_strobe)
    begin
      if (address == dst_pkg::prescale_and_enable_addr) sh_en <= write_data[0];
      if (address == dst_pkg::forced_output_values_addr) sh_lvl <= write_data;
      if (address == dst_pkg::interrupt_enables_addr) sh_ie <= write_data;
    end
  end

  // The pin level output is registered, so levels are judged only once writes have settled.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      quiet <= 2'h0;
    else if (write_strobe && (address == dst_pkg::prescale_and_enable_addr ||
                              address == dst_pkg::forced_output_values_addr))
      quiet <= 2'h0;
    else if (quiet != 2'h3)
      quiet <= quiet + 2'h1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_cmd_read;
    read_strobe && (address == dst_pkg::command_clear_addr || address == dst_pkg::command_set_addr);
  endsequence
  sequence s_zero_flag_write;
    write_strobe && address == dst_pkg::interrupt_flags_addr && write_data == 8'h00;
  endsequence

  property p_idle_zero;
    !read_strobe |=> read_data == 8'h00;
  endproperty
  property p_cmd_zero;
    s_cmd_read |=> read_data[7:2] == 6'h00;
  endproperty
  property p_split_map;
    read_strobe && address == dst_pkg::split_select_addr |=> read_data[7:1] == 7'h00;
  endproperty
  property p_flag_rsvd;
    read_strobe && address == dst_pkg::interrupt_flags_addr |=> (read_data & ~dst_pkg::flag_mask) == 8'h00;
  endproperty
  property p_unmapped;
    read_strobe && (address inside {[6'h06:6'h09], [6'h0C:6'h1F]}) |=> read_data == 8'h00;
  endproperty
  property p_no_override;
    waveform_mode_active[1:0] == 2'h0 |-> waveform_pin_override == 6'h00;
  endproperty
  property p_forced_level;
    !sh_en && quiet == 2'h3 |-> waveform_pin_n == {sh_lvl[6:4], sh_lvl[2:0]};
  endproperty
  property p_irq_gate;
    (sh_ie & dst_pkg::flag_mask) == 8'h00 |-> !interrupt_request;
  endproperty
  property p_irq_fall;
    $fell(interrupt_request) |-> $past(write_strobe) &&
      ($past(address) == dst_pkg::interrupt_flags_addr || $past(address) == dst_pkg::interrupt_enables_addr);
  endproperty
  property p_zero_keep;
    s_zero_flag_write ##0 interrupt_request |=> interrupt_request;
  endproperty

  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside read cycle");
  a_cmd_zero: assert property (p_cmd_zero) else $error("command field read nonzero");
  a_split_map: assert property (p_split_map) else $error("split register upper bits nonzero");
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag register reserved bits nonzero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
  a_no_override: assert property (p_no_override) else $error("pin owned outside waveform mode");
  a_forced_level: assert property (p_forced_level) else $error("forced level not on pins");
  a_irq_gate: assert property (p_irq_gate) else $error("request raised with no enable");
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without software write");
  a_zero_keep: assert property (p_zero_keep) else $error("zero write cleared a flag");
endmodule

// ===== verification/test_dst_split_timer.sv
/*
  Self-checking bench for the split timer control block.
  Assumes the byte register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module test_dst_split_timer;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic [5:0] address = 6'h00;
  logic [7:0] write_data = 8'h00;
  logic       write_strobe = 1'b0;
  logic       read_strobe = 1'b0;
  logic [2:0] waveform_mode_active = 3'h0;
  logic [7:0] read_data;
  logic [5:0] waveform_pin_n;
  logic [5:0] waveform_pin_override;
  logic       interrupt_request;
  logic [7:0] rv;
  logic [7:0] dlt;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  logic [5:0] rst_a [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0A, 6'h0B, 6'h26, 6'h10};
  logic [7:0] rst_e [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic [5:0] msk_a [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0A};
  logic [7:0] msk_e [5] = '{8'h0E, 8'h77, 8'h77, 8'h01, 8'h73};
  logic [7:0] ovr_e [4] = '{8'h00, 8'h07, 8'h38, 8'h3F};

  dst_split_timer DUT (.clock(clock), .nrst(nrst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .waveform_mode_active(waveform_mode_active),
    .read_data(read_data), .waveform_pin_n(waveform_pin_n), .waveform_pin_override(waveform_pin_override),
    .interrupt_request(interrupt_request));

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  task automatic rc(input string what, input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 rv = read_data;
    chk(what, rv, e);
  endtask

  task automatic irq(input logic e);
    #1 chk("interrupt request", {7'h00, interrupt_request}, {7'h00, e});
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The longest divider pass dominates the run; the margin covers all passes together.
  initial
  begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) rc("reset value", rst_a[i], rst_e[i]);
    wr(6'h10, 8'hAA);
    rc("unmapped", 6'h10, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(msk_a[i], 8'hFF - {7'h00, i == 0});
      rc("field mask", msk_a[i], msk_e[i]);
    end
    wr(dst_pkg::prescale_and_enable_addr, 8'h00);
    wr(dst_pkg::interrupt_enables_addr, 8'h00);
    wr(dst_pkg::command_set_addr, 8'h01);
    rc("command set", dst_pkg::command_set_addr, 8'h01);
    wr(dst_pkg::command_set_addr, 8'h02);
    rc("command set", dst_pkg::command_clear_addr, 8'h03);
    wr(dst_pkg::command_clear_addr, 8'h01);
    rc("command clear", dst_pkg::command_set_addr, 8'h02);
    wr(dst_pkg::command_clear_addr, 8'h00);
    rc("zero clear", dst_pkg::command_clear_addr, 8'h02);
    wr(dst_pkg::command_clear_addr, 8'h02);
    rc("command clear", dst_pkg::command_clear_addr, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock);
      waveform_mode_active <= 3'(m);
      @(posedge clock);
      #1 chk("pin ownership", {2'b00, waveform_pin_override}, ovr_e[m]);
    end
    wr(dst_pkg::forced_output_values_addr, 8'h15);
    repeat (4) @(posedge clock);
    #1 chk("forced level", {2'b00, waveform_pin_n}, 8'h0D);
    wr(dst_pkg::forced_output_values_addr, 8'h62);
    repeat (4) @(posedge clock);
    #1 chk("forced level", {2'b00, waveform_pin_n}, 8'h32);
    for (int c = 0; c < 8; c++)
    begin
      wr(dst_pkg::prescale_and_enable_addr, 8'h00);
      wr(dst_pkg::low_counter_value_addr, 8'h10);
      wr(dst_pkg::prescale_and_enable_addr, 8'(c * 2 + 1));
      repeat (4 * divs[c]) @(posedge clock);
      rc("count", dst_pkg::low_counter_value_addr, 8'h10 - 8'(c == 0 ? 5 : 4));
      dlt = 8'h10 - rv;
      chk("divided count", {7'h00, dlt >= 8'h03 && dlt <= 8'h06}, 8'h01);
    end
    wr(dst_pkg::prescale_and_enable_addr, 8'h01);
    wr(dst_pkg::low_counter_value_addr, 8'h80);
    rc("write priority", dst_pkg::low_counter_value_addr, 8'h7F);
    wr(dst_pkg::command_set_addr, 8'h0F);
    rc("reset while enabled", dst_pkg::low_counter_value_addr, 8'h7B);
    wr(dst_pkg::prescale_and_enable_addr, 8'h00);
    wr(dst_pkg::command_set_addr, 8'h0F);
    rc("hard reset low", dst_pkg::low_counter_value_addr, 8'h00);
    rc("hard reset high", dst_pkg::high_counter_value_addr, 8'h00);
    wr(dst_pkg::low_period_addr, 8'h70);
    wr(dst_pkg::low_counter_value_addr, 8'h11);
    wr(dst_pkg::command_set_addr, 8'h08);
    rc("no target", dst_pkg::low_counter_value_addr, 8'h11);
    wr(dst_pkg::command_set_addr, 8'h05);
    rc("reserved command", dst_pkg::low_counter_value_addr, 8'h11);
    wr(dst_pkg::command_set_addr, 8'h09);
    rc("restart low", dst_pkg::low_counter_value_addr, 8'h70);
    rc("restart low only", dst_pkg::high_counter_value_addr, 8'h00);
    wr(dst_pkg::command_clear_addr, 8'h0A);
    rc("restart high", dst_pkg::high_counter_value_addr, 8'hFF);
    wr(dst_pkg::interrupt_flags_addr, 8'h73);
    rc("flags cleared", dst_pkg::interrupt_flags_addr, 8'h00);
    wr(6'h28, 8'h80);
    wr(6'h2A, 8'h03);
    wr(6'h2C, 8'h90);
    wr(dst_pkg::low_counter_value_addr, 8'h06);
    wr(dst_pkg::high_counter_value_addr, 8'hF0);
    wr(dst_pkg::prescale_and_enable_addr, 8'h01);
    repeat (12) @(posedge clock);
    wr(dst_pkg::prescale_and_enable_addr, 8'h00);
    rc("low flags", dst_pkg::interrupt_flags_addr, 8'h21);
    wr(dst_pkg::high_counter_value_addr, 8'h02);
    wr(dst_pkg::prescale_and_enable_addr, 8'h01);
    repeat (12) @(posedge clock);
    wr(dst_pkg::prescale_and_enable_addr, 8'h00);
    rc("high flag", dst_pkg::interrupt_flags_addr, 8'h23);
    irq(1'b0);
    wr(dst_pkg::interrupt_enables_addr, 8'h10);
    irq(1'b0);
    wr(dst_pkg::interrupt_enables_addr, 8'h20);
    irq(1'b1);
    wr(dst_pkg::interrupt_flags_addr, 8'h00);
    rc("zero flag write", dst_pkg::interrupt_flags_addr, 8'h23);
    wr(dst_pkg::interrupt_flags_addr, 8'h01);
    rc("one flag cleared", dst_pkg::interrupt_flags_addr, 8'h22);
    irq(1'b1);
    wr(dst_pkg::interrupt_flags_addr, 8'h20);
    irq(1'b0);
    wr(dst_pkg::interrupt_enables_addr, 8'h02);
    irq(1'b1);
    wr(dst_pkg::interrupt_flags_addr, 8'h02);
    irq(1'b0);
    rc("all flags cleared", dst_pkg::interrupt_flags_addr, 8'h00);
    complete_run();
  end
endmodule

bind dst_split_timer dst_split_timer_chk u_chk (.clock(clock), .nrst(nrst), .address(address),
  .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
  .waveform_mode_active(waveform_mode_active), .read_data(read_data), .waveform_pin_n(waveform_pin_n),
  .waveform_pin_override(waveform_pin_override), .interrupt_request(interrupt_request));
